// >>> hw/adc_seq_pkg.sv
/*
 * Constants, states and pin carrier for the ADC conversion sequencer.
 * Assumes a single 200 MHz system clock; all times are converted here.
 */
package adc_seq_pkg;

   // ************************************************************
   // Clock and timing figures
   // ************************************************************
   localparam int CLK_MHZ        = 200;
   localparam int ACQ_NS         = 700;
   localparam int CONV_HI_NS     = 25;
   localparam int CONV_LO_NS     = 25;
   localparam int RST_HI_NS      = 50;
   localparam int RST_CONV_NS    = 25;
   localparam int CS_CONV_NS     = 10;
   localparam int RD_LO_NS       = 15;
   localparam int RD_HI_NS       = 15;
   localparam int BUSY_RISE_NS   = 15;
   localparam int BUSY_MAX_NS    = 126200;

   // Least times round up; busy maximum rounds down, busy rise limit takes one cycle over its floor
   localparam int ACQ_CYC      = (ACQ_NS * CLK_MHZ + 999) / 1000;
   localparam int CONV_HI_CYC  = (CONV_HI_NS * CLK_MHZ + 999) / 1000;
   localparam int CONV_LO_CYC  = (CONV_LO_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_HI_CYC   = (RST_HI_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_CONV_CYC = (RST_CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int CS_CONV_CYC  = (CS_CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_LO_CYC    = (RD_LO_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_HI_CYC    = (RD_HI_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_RISE_CYC = (BUSY_RISE_NS * CLK_MHZ) / 1000 + 1;
   localparam int BUSY_MAX_CYC = (BUSY_MAX_NS * CLK_MHZ) / 1000;

   // ************************************************************
   // Data shapes
   // ************************************************************
   localparam int CHANNELS = 8;
   localparam int WORD_W   = 16;
   localparam int OS_W     = 3;
   localparam int CNT_W    = 16;
   localparam int ACQ_W    = 8;

   // Pin levels driven toward the converter
   typedef struct packed {
      logic            conv_start_a;
      logic            conv_start_b;
      logic            adc_reset;
      logic            cs_n;
      logic            rd_n;
      logic [OS_W-1:0] oversample_ratio_pins;
   } adc_ctrl_s;

   localparam adc_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
                                        3'h0};

   typedef enum logic [3:0] {
      ST_RST_HI   = 4'h0,
      ST_RST_GAP  = 4'h1,
      ST_IDLE     = 4'h2,
      ST_ACQ      = 4'h3,
      ST_CONV_HI  = 4'h4,
      ST_CONV_LO  = 4'h5,
      ST_BUSY_UP  = 4'h6,
      ST_BUSY_DN  = 4'h7,
      ST_RD_LO    = 4'h8,
      ST_RD_HI    = 4'h9,
      ST_CS_GAP   = 4'hA
   } seq_state_e;

endpackage

// >>> hw/result_store.sv
/*
 * Small result memory: one word per converter channel.
 * Assumes one clock; read data appear one cycle after the address.
 */
`timescale 1ns/100ps
`default_nettype none
module result_store
   import adc_seq_pkg::*;
#(
   parameter int DEPTH = CHANNELS,
   parameter int W     = WORD_W,
   parameter int AW    = $clog2(DEPTH)
)(
   input  wire logic          sys_clk,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);

   logic [W-1:0] mem [DEPTH];

   // ************************************************************
   // Storage and registered read port
   // ************************************************************
   // No reset: contents are only meaningful after a completed read-out
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule
`default_nettype wire

// >>> hw/adc_convert_read_sequencer.sv
/*
 * Host-side sequencer: resets the converter, starts conversions,
 * then reads all channel words in parallel mode after busy falls.
 * Assumes busy and the result bus are synchronous to sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module adc_convert_read_sequencer
   import adc_seq_pkg::*;
#(
   parameter int BUSY_TIMEOUT = BUSY_MAX_CYC,
   parameter int NCH          = CHANNELS,
   parameter int AW           = $clog2(CHANNELS)
)(
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // User side
   input  wire logic              start_req,
   input  wire logic              reset_req,
   input  wire logic [OS_W-1:0]   os_ratio,
   output logic                   ready,
   output logic                   done,
   output logic                   timeout,
   input  wire logic [AW-1:0]     result_addr,
   output logic      [WORD_W-1:0] result_data,
   // Converter side
   output adc_ctrl_s              adc_ctrl,
   input  wire logic              busy,
   input  wire logic [WORD_W-1:0] parallel_result_bus,
   input  wire logic              first_channel_flag
);

   seq_state_e        state_r, state_nxt;
   logic [CNT_W-1:0]  cnt_r, cnt_nxt;
   logic [ACQ_W-1:0]  acq_r, acq_nxt;
   logic [AW-1:0]     chan_r, chan_nxt;
   adc_ctrl_s         ctrl_r, ctrl_nxt;
   logic              busy_r;
   logic              done_r, done_nxt;
   logic              tmo_r, tmo_nxt;
   logic              wr_en;
   logic              acq_ok;

   // Counter expiry test, used by every timed state except ST_ACQ
   function automatic logic expired(input logic [CNT_W-1:0] c,
                                    input int               lim);
      expired = (c >= CNT_W'(lim - 1));
   endfunction

   // ************************************************************
   // Acquisition timer since the last busy fall
   // ************************************************************
   // Saturates so an idle converter is always ready to start
   always_comb
   begin
      acq_nxt = acq_r;
      if (busy)
      begin
         acq_nxt = '0;
      end
      else if (acq_r != ACQ_W'(ACQ_CYC))
      begin
         acq_nxt = acq_r + ACQ_W'(1);
      end
   end

   // Start edge may only come after the full acquisition gap
   assign acq_ok = (acq_r == ACQ_W'(ACQ_CYC));

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         acq_r  <= ACQ_W'(ACQ_CYC);
         busy_r <= 1'b0;
      end
      else
      begin
         acq_r  <= acq_nxt;
         busy_r <= busy;
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r + CNT_W'(1);
      chan_nxt  = chan_r;
      ctrl_nxt  = ctrl_r;
      done_nxt  = 1'b0;
      tmo_nxt   = tmo_r;
      wr_en     = 1'b0;
      case (state_r)
         ST_RST_HI:
         begin
            ctrl_nxt.adc_reset = 1'b1;
            cnt_nxt = ctrl_r.adc_reset ? cnt_r + CNT_W'(1) : '0;
            if (expired(cnt_r, RST_HI_CYC))
            begin
               ctrl_nxt.adc_reset = 1'b0;
               cnt_nxt   = '0;
               state_nxt = ST_RST_GAP;
            end
         end
         ST_RST_GAP:
         begin
            if (expired(cnt_r, RST_CONV_CYC))
            begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE:
         begin
            cnt_nxt = '0;
            if (reset_req)
            begin
               ctrl_nxt.adc_reset = 1'b1;
               state_nxt = ST_RST_HI;
            end
            else if (start_req)
            begin
               tmo_nxt   = 1'b0;
               state_nxt = ST_ACQ;
            end
         end
         ST_ACQ:
         begin
            cnt_nxt = '0;
            if (acq_ok && !busy)
            begin
               // Ratio moves with the start edge, long after busy fell
               ctrl_nxt.oversample_ratio_pins = os_ratio;
               // Both edges in one cycle: zero skew between them
               ctrl_nxt.conv_start_a = 1'b1;
               ctrl_nxt.conv_start_b = 1'b1;
               state_nxt = ST_CONV_HI;
            end
         end
         ST_CONV_HI:
         begin
            if (expired(cnt_r, CONV_HI_CYC))
            begin
               ctrl_nxt.conv_start_a = 1'b0;
               ctrl_nxt.conv_start_b = 1'b0;
               cnt_nxt   = '0;
               state_nxt = ST_CONV_LO;
            end
         end
         ST_CONV_LO:
         begin
            // Low time kept before anything else may happen
            if (expired(cnt_r, CONV_LO_CYC))
            begin
               cnt_nxt   = '0;
               state_nxt = busy_r ? ST_BUSY_DN : ST_BUSY_UP;
            end
         end
         ST_BUSY_UP:
         begin
            // Busy normally rose at the leading start edge
            if (busy)
            begin
               cnt_nxt   = '0;
               state_nxt = ST_BUSY_DN;
            end
            else if (expired(cnt_r, BUSY_RISE_CYC))
            begin
               // Missed busy: treat conversion as already finished
               cnt_nxt   = '0;
               state_nxt = ST_BUSY_DN;
            end
         end
         ST_BUSY_DN:
         begin
            // No read during conversion, so the early window is unused
            // and select stays high while busy
            if (!busy)
            begin
               ctrl_nxt.cs_n = 1'b0;
               chan_nxt  = '0;
               cnt_nxt   = '0;
               state_nxt = ST_RD_LO;
            end
            else if (expired(cnt_r, BUSY_TIMEOUT))
            begin
               tmo_nxt   = 1'b1;
               done_nxt  = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_RD_LO:
         begin
            // Strobe follows select by at least one cycle
            ctrl_nxt.rd_n = ctrl_r.cs_n;
            if (ctrl_r.rd_n)
            begin
               cnt_nxt = '0;
            end
            else if (expired(cnt_r, RD_LO_CYC))
            begin
               wr_en     = 1'b1;
               ctrl_nxt.rd_n = 1'b1;
               cnt_nxt   = '0;
               state_nxt = ST_RD_HI;
            end
         end
         ST_RD_HI:
         begin
            if (chan_r == AW'(NCH - 1))
            begin
               // Select rises only after the strobe has risen
               ctrl_nxt.cs_n = 1'b1;
               cnt_nxt   = '0;
               state_nxt = ST_CS_GAP;
            end
            else if (expired(cnt_r, RD_HI_CYC))
            begin
               ctrl_nxt.rd_n = 1'b0;
               chan_nxt  = chan_r + AW'(1);
               cnt_nxt   = '0;
               state_nxt = ST_RD_LO;
            end
         end
         ST_CS_GAP:
         begin
            if (expired(cnt_r, CS_CONV_CYC))
            begin
               done_nxt  = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default:
         begin
            ctrl_nxt  = CTRL_RESET;
            cnt_nxt   = '0;
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Reset state holds the device reset pulse from power-up
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= ST_RST_HI;
         cnt_r   <= '0;
         chan_r  <= '0;
         ctrl_r  <= CTRL_RESET;
         done_r  <= 1'b0;
         tmo_r   <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         chan_r  <= chan_nxt;
         ctrl_r  <= ctrl_nxt;
         done_r  <= done_nxt;
         tmo_r   <= tmo_nxt;
      end
   end

   // ************************************************************
   // Result storage and outputs
   // ************************************************************
   // Channel order is sequential; the first-channel flag is not checked
   result_store #(
      .DEPTH (NCH),
      .W     (WORD_W),
      .AW    (AW)
   ) u_store (
      .sys_clk (sys_clk),
      .wr_en   (wr_en),
      .wr_addr (chan_r),
      .wr_data (parallel_result_bus),
      .rd_addr (result_addr),
      .rd_data (result_data)
   );

   assign adc_ctrl = ctrl_r;
   assign done     = done_r;
   assign timeout  = tmo_r;
   assign ready    = (state_r == ST_IDLE);

endmodule
`default_nettype wire

// >>> dv/seq_props.sv
/*
 * Pin timing checker for the conversion sequencer.
 * Assumes a bind onto the sequencer top; one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module seq_props
   import adc_seq_pkg::*;
(
   input wire logic      sys_clk,
   input wire logic      rstn,
   input wire adc_ctrl_s adc_ctrl,
   input wire logic      busy
);
   // ************************************************************
   // Helper logic
   // ************************************************************
   logic [7:0] idle_r;
   logic [7:0] idle_nxt;
   wire        any_st = adc_ctrl.conv_start_a | adc_ctrl.conv_start_b;
   wire        both_st = adc_ctrl.conv_start_a & adc_ctrl.conv_start_b;

   // Idle cycles since busy fell; saturates so reset reads as long ago
   always_comb
   begin
      idle_nxt = idle_r;
      if (busy)
         idle_nxt = 8'h00;
      else if (idle_r != 8'hFF)
         idle_nxt = idle_r + 8'h01;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         idle_r <= 8'hFF;
      else
         idle_r <= idle_nxt;
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_hi5;
      adc_ctrl.conv_start_a [*5];
   endsequence
   sequence s_lo5;
      !adc_ctrl.conv_start_a [*5];
   endsequence

   a_start_high: assert property (
      $rose(adc_ctrl.conv_start_a) |-> s_hi5) else $error("start short");
   a_start_low: assert property (
      $fell(adc_ctrl.conv_start_a) |-> s_lo5) else $error("gap short");
   a_reset_width: assert property (
      $rose(adc_ctrl.adc_reset) |-> adc_ctrl.adc_reset [*8] ##1
      adc_ctrl.adc_reset [*2]) else $error("reset pulse short");
   a_reset_gap: assert property (
      $fell(adc_ctrl.adc_reset) |-> !any_st [*5]) else $error("early start");
   a_acq_space: assert property (
      $rose(both_st) |-> int'(idle_r) >= ACQ_CYC) else $error("acq short");
   a_start_pair: assert property (
      $rose(adc_ctrl.conv_start_a) |-> $rose(adc_ctrl.conv_start_b))
      else $error("start edges apart");
   a_read_window: assert property (
      !adc_ctrl.cs_n |-> !busy) else $error("select while busy");
   a_cs_to_start: assert property (
      $rose(any_st) |-> adc_ctrl.cs_n && $past(adc_ctrl.cs_n) &&
      $past(adc_ctrl.cs_n, 2)) else $error("select too close");
   a_rd_in_cs: assert property (
      !adc_ctrl.rd_n |-> !adc_ctrl.cs_n) else $error("strobe outside");
   a_os_hold: assert property (
      busy |=> $stable(adc_ctrl.oversample_ratio_pins))
      else $error("ratio moved");
   a_os_after: assert property (
      $fell(busy) |-> $stable(adc_ctrl.oversample_ratio_pins) [*5])
      else $error("ratio hold short");
endmodule
`default_nettype wire

// >>> dv/adc_model.sv
/*
 * Behavioural converter: busy timing and result words.
 * Assumes pins registered on sys_clk by the sequencer.
 */
`timescale 1ns/100ps
`default_nettype none
module adc_model
   import adc_seq_pkg::*;
#(
   parameter int BASE_CYC = 248
)(
   input  wire logic         sys_clk,
   input  wire adc_ctrl_s    adc_ctrl,
   input  wire logic         stuck,
   output logic              busy,
   output logic [WORD_W-1:0] parallel_result_bus,
   output logic              first_channel_flag
);
   // ************************************************************
   // Device behaviour
   // ************************************************************
   logic              both_q = 1'b0;
   logic              rd_q = 1'b1;
   logic [2:0]        ch = 3'h0;
   logic [3:0]        num = 4'h0;
   logic [WORD_W-1:0] last = 16'h0000;
   int                left = 0;
   wire               both = adc_ctrl.conv_start_a & adc_ctrl.conv_start_b;
   wire               sel = !adc_ctrl.cs_n & !adc_ctrl.rd_n;
   wire [WORD_W-1:0]  word = {8'hC3, num, 1'b0, ch};

   initial busy = 1'b0;

   // Leading start edge starts busy; ratio stretches it
   always @(posedge sys_clk)
   begin
      both_q <= both;
      rd_q   <= adc_ctrl.rd_n;
      if (adc_ctrl.adc_reset)
      begin
         busy <= 1'b0;
         num  <= 4'h0;
      end
      else if (both && !both_q && !busy)
      begin
         busy <= 1'b1;
         left <= BASE_CYC << adc_ctrl.oversample_ratio_pins;
         num  <= num + 4'h1;
      end
      else if (busy && !stuck)
      begin
         left <= left - 1;
         busy <= (left > 1);
      end
      if (both && !both_q)
         ch <= 3'h0;
      else if (!rd_q && adc_ctrl.rd_n)
         ch <= ch + 3'h1;
      if (sel)
         last <= word;
   end

   // Released bus shows a changed value, never the stale word
   assign parallel_result_bus = sel ? word : ~last;
   assign first_channel_flag = sel ? (ch == 3'h0) : !last[0];
endmodule
`default_nettype wire

// >>> dv/tb.sv
/*
 * Self-checking bench for the conversion sequencer.
 * Assumes the converter model and checker are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      tests_run++; \
      if ((got) !== (ex)) \
      begin \
         fail_count++; \
         $display("MISMATCH %s exp %h got %h", nm, ex, got); \
      end \
   end
module tb
   import adc_seq_pkg::*;
;
   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic              sys_clk, rstn, start_req, reset_req, stuck;
   logic [OS_W-1:0]   os_ratio;
   logic [2:0]        result_addr;
   logic              ready, done, timeout, busy, first_flag;
   logic [WORD_W-1:0] result_data, bus;
   adc_ctrl_s         adc_ctrl;
   int                fail_count = 0;
   int                tests_run = 0;
   int                cyc = 0;
   logic [3:0]        num_exp = 4'h0;

   // Short timeout keeps the stuck-busy case brief
   adc_convert_read_sequencer #(.BUSY_TIMEOUT(500)) dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .start_req(start_req),
      .reset_req(reset_req), .os_ratio(os_ratio), .ready(ready),
      .done(done), .timeout(timeout), .result_addr(result_addr),
      .result_data(result_data), .adc_ctrl(adc_ctrl), .busy(busy),
      .parallel_result_bus(bus), .first_channel_flag(first_flag));

   // Shortened conversion so ratios 0 to 3 finish before the timeout
   adc_model #(.BASE_CYC(40)) adc_u (
      .sys_clk(sys_clk), .adc_ctrl(adc_ctrl), .stuck(stuck),
      .busy(busy), .parallel_result_bus(bus),
      .first_channel_flag(first_flag));

   // ************************************************************
   // Clock, hang guard and tasks
   // ************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (fail_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Waits for ready (want_done low) or for the done pulse
   task automatic wait_sig(input logic want_done, input int lim);
      int n;
      n = 0;
      while ((want_done ? done : ready) !== 1'b1 && n < lim)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask

   task automatic go(input logic [2:0] os);
      wait_sig(1'b0, 400);
      `CHK("ready", 1'b1, ready)
      os_ratio  = os;
      start_req = 1'b1;
      @(negedge sys_clk);
      start_req = 1'b0;
   endtask

   task automatic t_convert(input logic [2:0] os);
      num_exp = num_exp + 4'h1;
      go(os);
      repeat (20) @(negedge sys_clk);
      start_req = 1'b1;
      @(negedge sys_clk);
      start_req = 1'b0;
      wait_sig(1'b1, 2000);
      `CHK("done", 1'b1, done)
      `CHK("timeout", 1'b0, timeout)
      `CHK("os_pins", os, adc_ctrl.oversample_ratio_pins)
      for (int a = 0; a < CHANNELS; a++)
      begin
         result_addr = 3'(a);
         @(negedge sys_clk);
         `CHK("word", {8'hC3, num_exp, 1'b0, 3'(a)}, result_data)
      end
   endtask

   task automatic t_stuck();
      stuck   = 1'b1;
      num_exp = num_exp + 4'h1;
      go(3'h0);
      wait_sig(1'b1, 2000);
      `CHK("done", 1'b1, done)
      `CHK("timeout", 1'b1, timeout)
      stuck = 1'b0;
   endtask

   task automatic t_reset();
      int n;
      n = 0;
      wait_sig(1'b0, 400);
      reset_req = 1'b1;
      @(negedge sys_clk);
      reset_req = 1'b0;
      // Pulse is already high here, so sample before each wait
      repeat (30)
      begin
         if (adc_ctrl.adc_reset === 1'b1)
            n++;
         @(negedge sys_clk);
      end
      `CHK("rst_hi", RST_HI_CYC, n)
      num_exp = 4'h0;
   endtask

   // Main sequence: back-to-back ratios, hang, device reset
   initial
   begin
      rstn        = 1'b0;
      start_req   = 1'b0;
      reset_req   = 1'b0;
      stuck       = 1'b0;
      os_ratio    = 3'h0;
      result_addr = 3'h0;
      repeat (16) @(negedge sys_clk);
      rstn = 1'b1;
      for (int k = 0; k < 4; k++)
         t_convert(3'(k));
      t_stuck();
      t_convert(3'h0);
      t_reset();
      t_convert(3'h2);
      report_and_stop();
   end
endmodule

bind adc_convert_read_sequencer seq_props chk_u (
   .sys_clk(sys_clk), .rstn(rstn), .adc_ctrl(adc_ctrl), .busy(busy));
`default_nettype wire
